// ===== core/tos_output_stage.sv
// Thermal overload output stage: thresholds, trip delay, blocking, status
// What this block does
// - Alarm 1 gated by its enable
// - Alarm 1 at capacity over level, 40%
// - Alarm 2 gated by own enable, default off
// - Alarm 2 at capacity over level, 40%
// - Inhibit gated, asserts at level, 80%
// - Trip at level after 5 ms-step delay
// - Outputs depend only on thermal capacity
// - Block input sampled each processing cycle
// - Unblocked pick-up raises start, times trip
// - Blocked pick-up raises blocked, stops there
// - Later blocking clears start, resets timing
// - Report condition; normal drives no outputs but start
// - Report logical node behaviour mode
// - Classify load from measured current
// - Bad service factor: use 1.0, flag
// - Bad ambient settings: use 1.0, flag
// - Bad nominal current: use 1.0, flag
// - Flag inconsistent ambient k, no substitute
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`include "tos_params.svh"
`timescale 1ns/10ps
`default_nettype none

module tos_output_stage #(
  parameter int STEP_CYCLES = `TOS_STEP_CYCLES  // Clocks per 5 ms delay step
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [7:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  output logic      [31:0] avsReadData,
  output logic             avsWaitRequest,
  // Thermal image calculator
  input  wire logic        cycleStart,
  input  wire logic [15:0] capacity,
  input  wire logic [15:0] measCurrent,
  input  wire logic [15:0] pickupCurrent,
  input  wire logic [15:0] serviceFactor,
  input  wire logic        serviceFactorBad,
  input  wire logic [15:0] ambientK,
  input  wire logic        ambientBad,
  input  wire logic [15:0] nominalCurr,
  input  wire logic        nominalBad,
  input  wire logic        ambientKInconsistent,
  // Blocking matrix
  input  wire logic        blockIn,
  // Protection outputs
  output logic             alarm1Out,
  output logic             alarm2Out,
  output logic             inhibitOut,
  output logic             tripOut,
  output logic             startOut,
  output logic             blockedOut,
  // Status
  output logic      [2:0]  condition,
  output logic      [2:0]  lnBehaviour,
  output logic      [1:0]  loadStatus,
  output logic             sfFault,
  output logic             ambFault,
  output logic             nomFault,
  output logic             ambKFault,
  // Values in use after substitution
  output logic      [15:0] sfUsed,
  output logic      [15:0] ambKUsed,
  output logic      [15:0] nomCurrUsed
);

  // Refuse a step count the prescaler cannot hold
  initial begin
    if (STEP_CYCLES < 1 || STEP_CYCLES > 16777215) begin
      $error("STEP_CYCLES out of range");
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////
  logic [7:0]  ctrl_reg;               // Enables and node mode
  logic [10:0] lvl_reg [0:3];          // Alarm 1, alarm 2, inhibit, trip
  logic [19:0] tripDly_reg;            // Trip delay in steps
  logic        ack_reg;                // Bus answer cycle
  logic [23:0] preCnt_reg;             // Step prescaler
  logic [19:0] stepCnt_reg;            // Elapsed delay steps
  logic        stepTick;               // One step elapsed
  logic        timerDone;              // Delay reached
  logic        pickUp;                 // Capacity at trip level
  logic        blockNow;               // Effective block at sample
  logic        lnOff;                  // Node switched off
  logic [2:0]  levelOut_reg;           // Gated level outputs
  logic [31:0] status;                 // Status word
  tos_pkg::tos_state_t state_reg;      // Trip path state
  tos_pkg::tos_state_t state_next;
  tos_pkg::tos_ln_t    lnMode;         // Node mode from control

  // Threshold compare, capacity in 0.1 % units
  function automatic logic geThr(input logic [15:0] cap, input logic [10:0] lvl);
    geThr = cap >= {5'h00, lvl};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Avalon-MM slave
  ////////////////////////////////////////////////////////////////////
  // One wait cycle on every access keeps read data registered
  assign avsWaitRequest = (avsRead | avsWrite) & ~ack_reg;

  // Answer flag, high for the single completing cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avsRead | avsWrite) & ~ack_reg;
    end
  end

  // Register writes take effect at the completing edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_reg    <= `TOS_RST_CTRL;
      lvl_reg[0]  <= `TOS_RST_A1_LVL;
      lvl_reg[1]  <= `TOS_RST_A2_LVL;
      lvl_reg[2]  <= `TOS_RST_INH_LVL;
      lvl_reg[3]  <= `TOS_RST_TRIP_LVL;
      tripDly_reg <= `TOS_RST_TRIP_DLY;
    end else if (avsWrite && ack_reg) begin
      // Levels above range clamp to the top of range
      if (avsAddress == `TOS_OFF_CTRL) begin
        ctrl_reg <= avsWriteData[7:0];
      end else if (avsAddress == `TOS_OFF_A1_LVL) begin
        lvl_reg[0] <= clampLvl(avsWriteData);
      end else if (avsAddress == `TOS_OFF_A2_LVL) begin
        lvl_reg[1] <= clampLvl(avsWriteData);
      end else if (avsAddress == `TOS_OFF_INH_LVL) begin
        lvl_reg[2] <= clampLvl(avsWriteData);
      end else if (avsAddress == `TOS_OFF_TRIP_LVL) begin
        lvl_reg[3] <= clampLvl(avsWriteData);
      end else if (avsAddress == `TOS_OFF_TRIP_DLY) begin
        if (avsWriteData > {12'h000, `TOS_DLY_MAX}) begin
          tripDly_reg <= `TOS_DLY_MAX;
        end else begin
          tripDly_reg <= avsWriteData[19:0];
        end
      end
      // Unmapped and read-only offsets ignore writes
    end
  end

  // Saturating level conversion
  function automatic logic [10:0] clampLvl(input logic [31:0] d);
    if (d > {21'h000000, `TOS_LVL_MAX}) begin
      clampLvl = `TOS_LVL_MAX;
    end else begin
      clampLvl = d[10:0];
    end
  endfunction

  // Read data captured in the wait cycle, held for the answer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avsReadData <= 32'h00000000;
    end else if (avsRead && !ack_reg) begin
      if (avsAddress == `TOS_OFF_CTRL) begin
        avsReadData <= {24'h000000, ctrl_reg};
      end else if (avsAddress == `TOS_OFF_A1_LVL) begin
        avsReadData <= {21'h000000, lvl_reg[0]};
      end else if (avsAddress == `TOS_OFF_A2_LVL) begin
        avsReadData <= {21'h000000, lvl_reg[1]};
      end else if (avsAddress == `TOS_OFF_INH_LVL) begin
        avsReadData <= {21'h000000, lvl_reg[2]};
      end else if (avsAddress == `TOS_OFF_TRIP_LVL) begin
        avsReadData <= {21'h000000, lvl_reg[3]};
      end else if (avsAddress == `TOS_OFF_TRIP_DLY) begin
        avsReadData <= {12'h000, tripDly_reg};
      end else if (avsAddress == `TOS_OFF_STATUS) begin
        avsReadData <= status;
      end else if (avsAddress == `TOS_OFF_CAPACITY) begin
        avsReadData <= {16'h0000, capacity};
      end else begin
        avsReadData <= 32'h00000000;   // Unmapped reads zero
      end
    end
  end

  // Status word, reserved bits zero
  assign status = {8'h00, ambKFault, nomFault, ambFault, sfFault,
                   2'h0, loadStatus, 1'b0, lnBehaviour, 1'b0, condition,
                   2'h0, blockedOut, startOut, tripOut, inhibitOut,
                   alarm2Out, alarm1Out};

  ////////////////////////////////////////////////////////////////////
  // Mode and pick-up
  ////////////////////////////////////////////////////////////////////
  // Unknown codes behave as off, the safe reading
  always_comb begin
    case (ctrl_reg[`TOS_CTRL_LN_MSB:`TOS_CTRL_LN_LSB])
      3'b000:  lnMode = tos_pkg::LN_ON;
      3'b001:  lnMode = tos_pkg::LN_BLOCKED;
      3'b010:  lnMode = tos_pkg::LN_TEST;
      3'b011:  lnMode = tos_pkg::LN_TEST_BLK;
      default: lnMode = tos_pkg::LN_OFF;
    endcase
  end

  assign lnOff  = (lnMode == tos_pkg::LN_OFF);
  // Capacity is the only operating criterion
  assign pickUp = !lnOff && geThr(capacity, lvl_reg[3]);
  // Blocking matrix input, or a blocked node mode
  assign blockNow = blockIn || lnMode == tos_pkg::LN_BLOCKED ||
                    lnMode == tos_pkg::LN_TEST_BLK;

  ////////////////////////////////////////////////////////////////////
  // Alarm and inhibit outputs
  ////////////////////////////////////////////////////////////////////
  // Each level output follows capacity at every cycle sample
  for (genvar i = 0; i < 3; i++) begin : g_level
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        levelOut_reg[i] <= 1'b0;
      end else if (cycleStart) begin
        // Enable gates output, drops below level
        levelOut_reg[i] <= ctrl_reg[i] && !lnOff &&
                           geThr(capacity, lvl_reg[i]);
      end
    end
  end

  assign alarm1Out  = levelOut_reg[0];
  assign alarm2Out  = levelOut_reg[1];
  assign inhibitOut = levelOut_reg[2];

  ////////////////////////////////////////////////////////////////////
  // Trip delay timer
  ////////////////////////////////////////////////////////////////////
  assign stepTick  = (preCnt_reg == 24'(STEP_CYCLES - 1));
  assign timerDone = (stepCnt_reg >= tripDly_reg);

  // Runs only while started; any other state restarts it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      preCnt_reg  <= 24'h000000;
      stepCnt_reg <= 20'h00000;
    end else if (state_reg != tos_pkg::ST_START) begin
      preCnt_reg  <= 24'h000000;
      stepCnt_reg <= 20'h00000;
    end else if (stepTick) begin
      preCnt_reg  <= 24'h000000;
      stepCnt_reg <= stepCnt_reg + 20'h00001;
    end else begin
      preCnt_reg  <= preCnt_reg + 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Trip path state machine
  ////////////////////////////////////////////////////////////////////
  // Block is looked at only on the cycle sample
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tos_pkg::ST_IDLE, tos_pkg::ST_BLOCKED: begin
        if (cycleStart) begin
          if (!pickUp) begin
            state_next = tos_pkg::ST_IDLE;
          end else if (blockNow) begin
            state_next = tos_pkg::ST_BLOCKED;
          end else if (tripDly_reg == 20'h00000) begin
            state_next = tos_pkg::ST_TRIP;
          end else begin
            state_next = tos_pkg::ST_START;
          end
        end
      end
      tos_pkg::ST_START: begin
        if (cycleStart && !pickUp) begin
          state_next = tos_pkg::ST_IDLE;
        end else if (cycleStart && blockNow) begin
          state_next = tos_pkg::ST_BLOCKED;
        end else if (timerDone) begin
          state_next = tos_pkg::ST_TRIP;
        end
      end
      tos_pkg::ST_TRIP: begin
        if (cycleStart && !pickUp) begin
          state_next = tos_pkg::ST_IDLE;
        end else if (cycleStart && blockNow) begin
          state_next = tos_pkg::ST_BLOCKED;
        end
      end
      default: state_next = tos_pkg::ST_IDLE;
    endcase
  end

  // State and its decoded outputs, all registered
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg  <= tos_pkg::ST_IDLE;
      startOut   <= 1'b0;
      tripOut    <= 1'b0;
      blockedOut <= 1'b0;
    end else begin
      state_reg  <= state_next;
      // Start stays up while the trip is held
      startOut   <= state_next == tos_pkg::ST_START ||
                    state_next == tos_pkg::ST_TRIP;
      tripOut    <= state_next == tos_pkg::ST_TRIP;
      blockedOut <= state_next == tos_pkg::ST_BLOCKED;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Condition and mode report
  ////////////////////////////////////////////////////////////////////
  // Highest severity wins; normal only when nothing but start drives
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      condition   <= tos_pkg::COND_NORMAL;
      lnBehaviour <= tos_pkg::LN_ON;
    end else begin
      lnBehaviour <= lnMode;
      if (blockedOut) begin
        condition <= tos_pkg::COND_BLOCKED;
      end else if (tripOut) begin
        condition <= tos_pkg::COND_TRIP;
      end else if (inhibitOut) begin
        condition <= tos_pkg::COND_INHIBIT;
      end else if (alarm2Out) begin
        condition <= tos_pkg::COND_ALARM2;
      end else if (alarm1Out) begin
        condition <= tos_pkg::COND_ALARM1;
      end else begin
        condition <= tos_pkg::COND_NORMAL;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Load status
  ////////////////////////////////////////////////////////////////////
  // Classified once per cycle sample from measured current
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      loadStatus <= tos_pkg::LOAD_LIGHT;
    end else if (cycleStart) begin
      if (measCurrent < `TOS_LIGHT_LIM) begin
        loadStatus <= tos_pkg::LOAD_LIGHT;
      end else if (measCurrent <= pickupCurrent) begin
        loadStatus <= tos_pkg::LOAD_NORMAL;
      end else if (measCurrent <= `TOS_HIGH_LIM) begin
        loadStatus <= tos_pkg::LOAD_OVER;
      end else begin
        loadStatus <= tos_pkg::LOAD_HIGH;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Setting faults and substitution
  ////////////////////////////////////////////////////////////////////
  // Flags follow the inputs; they clear as soon as a fault goes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sfFault     <= 1'b0;
      ambFault    <= 1'b0;
      nomFault    <= 1'b0;
      ambKFault   <= 1'b0;
      sfUsed      <= `TOS_FIXED_ONE;
      ambKUsed    <= `TOS_FIXED_ONE;
      nomCurrUsed <= `TOS_FIXED_ONE;
    end else begin
      sfFault     <= serviceFactorBad;
      ambFault    <= ambientBad;
      nomFault    <= nominalBad;
      ambKFault   <= ambientKInconsistent;
      sfUsed      <= serviceFactorBad ? `TOS_FIXED_ONE : serviceFactor;
      ambKUsed    <= ambientBad ? `TOS_FIXED_ONE : ambientK;
      nomCurrUsed <= nominalBad ? `TOS_FIXED_ONE : nominalCurr;
    end
  end

endmodule // tos_output_stage

`default_nettype wire

// ===== core/tos_params.svh
// Constants of the thermal overload output stage: offsets, reset values, timing
`ifndef TOS_PARAMS_SVH
`define TOS_PARAMS_SVH
// Timing
`define TOS_CLK_HZ        25000000
`define TOS_STEP_MS       5
`define TOS_STEP_CYCLES   ((`TOS_CLK_HZ / 1000) * `TOS_STEP_MS)
// Register byte offsets
`define TOS_OFF_CTRL      8'h00
`define TOS_OFF_A1_LVL    8'h04
`define TOS_OFF_A2_LVL    8'h08
`define TOS_OFF_INH_LVL   8'h0C
`define TOS_OFF_TRIP_LVL  8'h10
`define TOS_OFF_TRIP_DLY  8'h14
`define TOS_OFF_STATUS    8'h18
`define TOS_OFF_CAPACITY  8'h1C
// Control fields
`define TOS_CTRL_EN_A1    0
`define TOS_CTRL_EN_A2    1
`define TOS_CTRL_EN_INH   2
`define TOS_CTRL_LN_LSB   4
`define TOS_CTRL_LN_MSB   6
// Reset values, levels in 0.1 % units, delay in 5 ms steps
`define TOS_RST_CTRL      8'h00
`define TOS_RST_A1_LVL    11'h190
`define TOS_RST_A2_LVL    11'h190
`define TOS_RST_INH_LVL   11'h320
`define TOS_RST_TRIP_LVL  11'h3E8
`define TOS_RST_TRIP_DLY  20'h00000
`define TOS_LVL_MAX       11'h5DC
`define TOS_DLY_MAX       20'hAFC80
// Status fields
`define TOS_ST_COND_LSB   8
`define TOS_ST_LN_LSB     12
`define TOS_ST_LOAD_LSB   16
`define TOS_ST_FAULT_LSB  20
// Substitute value 1.0 in 8.8 fixed point
`define TOS_FIXED_ONE     16'h0100
// Load limits in 0.1 % of nominal current
`define TOS_LIGHT_LIM     16'h000A
`define TOS_HIGH_LIM      16'h07D0
`endif

// ===== core/tos_pkg.sv
// Types of the thermal overload output stage
package tos_pkg;
  // Trip path state
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_START   = 2'b01,
    ST_BLOCKED = 2'b10,
    ST_TRIP    = 2'b11
  } tos_state_t;
  // Operating condition
  typedef enum logic [2:0] {
    COND_NORMAL  = 3'b000,
    COND_ALARM1  = 3'b001,
    COND_ALARM2  = 3'b010,
    COND_INHIBIT = 3'b011,
    COND_TRIP    = 3'b100,
    COND_BLOCKED = 3'b101
  } tos_cond_t;
  // Logical node behaviour
  typedef enum logic [2:0] {
    LN_ON       = 3'b000,
    LN_BLOCKED  = 3'b001,
    LN_TEST     = 3'b010,
    LN_TEST_BLK = 3'b011,
    LN_OFF      = 3'b100
  } tos_ln_t;
  // Load status
  typedef enum logic [1:0] {
    LOAD_LIGHT  = 2'b00,
    LOAD_NORMAL = 2'b01,
    LOAD_OVER   = 2'b10,
    LOAD_HIGH   = 2'b11
  } tos_load_t;
endpackage

// ===== verif/tos_calc_model.sv
// Thermal image calculator and blocking matrix model
`timescale 1ns/10ps
`default_nettype none

module tos_calc_model #(
  parameter int PERIOD = 10  // Clocks per processing cycle
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Values requested by the bench
  input  wire logic [15:0] capReq,
  input  wire logic        blkReq,
  // Toward the stage
  output logic             cycleStart,
  output logic      [15:0] capacity,
  output logic             blockIn
);
  int cnt;  // Position in processing cycle

  // New values launch with the pulse, so they are held a full cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt        <= 0;
      cycleStart <= 1'b0;
      capacity   <= 16'h0000;
      blockIn    <= 1'b0;
    end else begin
      cycleStart <= (cnt == PERIOD - 1);
      cnt        <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      if (cnt == PERIOD - 1) begin
        capacity <= capReq;
        blockIn  <= blkReq;
      end
    end
  end
endmodule  // tos_calc_model

`default_nettype wire

// ===== verif/tos_output_stage_monitor.sv
// Port checker for the thermal overload output stage
`timescale 1ns/10ps
`default_nettype none

module tos_output_stage_monitor (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Inputs watched
  input wire logic        avsWrite,
  input wire logic        cycleStart,
  input wire logic        blockIn,
  input wire logic [15:0] measCurrent,
  input wire logic        serviceFactorBad,
  input wire logic        ambientKInconsistent,
  // Outputs watched
  input wire logic        alarm1Out,
  input wire logic        alarm2Out,
  input wire logic        inhibitOut,
  input wire logic        tripOut,
  input wire logic        startOut,
  input wire logic        blockedOut,
  input wire logic [2:0]  condition,
  input wire logic [1:0]  loadStatus,
  input wire logic        sfFault,
  input wire logic        ambFault,
  input wire logic        nomFault,
  input wire logic        ambKFault,
  input wire logic [15:0] sfUsed,
  input wire logic [15:0] ambKUsed,
  input wire logic [15:0] nomCurrUsed
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Alarm, inhibit and blocked outputs move only at a sample, unless settings were just written
  a_hold_between: assert property (!cycleStart && !avsWrite && !$past(avsWrite) |=>
    $stable({alarm1Out, alarm2Out, inhibitOut, blockedOut})) else $error("moved off sample");
  a_block_clears: assert property (cycleStart && blockIn |=> !startOut && !tripOut)
    else $error("block missed");
  a_trip_start: assert property ($rose(tripOut) |-> startOut && !blockedOut)
    else $error("trip without start");
  a_cond_busy: assert property ((alarm1Out || alarm2Out || inhibitOut || tripOut || blockedOut)
    |=> condition != 3'h0) else $error("normal with outputs");
  a_cond_trip: assert property (tripOut |=> condition == 3'h4)
    else $error("condition not trip");
  a_light_load: assert property (cycleStart && measCurrent < 16'h000A |=> loadStatus == 2'h0)
    else $error("light load missed");
  a_high_load: assert property (cycleStart && measCurrent > 16'h07D0 |=> loadStatus == 2'h3)
    else $error("high overload missed");
  a_sf_follow: assert property (serviceFactorBad |=> sfFault)
    else $error("sf flag missed");
  a_sf_subst: assert property (sfFault |-> sfUsed == 16'h0100)
    else $error("sf not replaced");
  a_amb_subst: assert property (ambFault |-> ambKUsed == 16'h0100)
    else $error("amb not replaced");
  a_nom_subst: assert property (nomFault |-> nomCurrUsed == 16'h0100)
    else $error("nom not replaced");
  a_ambk_flag: assert property (ambientKInconsistent |=> ambKFault)
    else $error("k flag missed");

  // Main scenarios reached
  c_trip: cover property ($rose(tripOut));
  c_block: cover property ($rose(blockedOut));
  c_alarm: cover property ($rose(alarm1Out));
endmodule  // tos_output_stage_monitor

bind tos_output_stage tos_output_stage_monitor mon (.*);

`default_nettype wire

// ===== verif/tos_output_stage_tb.sv
// Self-checking bench of the thermal overload output stage
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

module tos_output_stage_tb;
  localparam int STEP = 4;  // Short delay step keeps runs brief
  localparam int PER  = 10; // Processing cycle length
  logic clock, rst, avsRead, avsWrite, avsWaitRequest, cycleStart, blockIn, blkReq;
  logic [7:0]  avsAddress;
  logic [31:0] avsWriteData, avsReadData, rd;
  logic [15:0] capacity, capReq, measCurrent, serviceFactor, sfUsed, ambKUsed, nomCurrUsed;
  logic [3:0]  bad;  // Setting fault inputs
  logic alarm1Out, alarm2Out, inhibitOut, tripOut, startOut, blockedOut;
  logic sfFault, ambFault, nomFault, ambKFault;
  logic [2:0]  condition, lnBehaviour;
  logic [1:0]  loadStatus;
  int bad_count, n_tests, cyc;

  tos_output_stage #(.STEP_CYCLES(STEP)) dut (.*, .pickupCurrent(16'h041A), .serviceFactorBad(bad[0]),
    .ambientK(16'h0140), .ambientBad(bad[1]), .nominalCurr(16'h00C0), .nominalBad(bad[2]),
    .ambientKInconsistent(bad[3]));
  tos_calc_model #(.PERIOD(PER)) calc (.*);

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Hang guard: a run far past the expected length fails
  always @(posedge clock) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      final_report;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One bus cycle; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= w;
    avsRead <= ~w;
    do @(posedge clock); while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask

  // Two samples then a margin, so registered outputs have landed
  task automatic settle;
    repeat (2) @(posedge clock iff cycleStart === 1'b1);
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic setc(input logic [15:0] c, input logic b);
    @(posedge clock);
    capReq <= c;
    blkReq <= b;
    settle;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0]  offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [31:0] exps [6] = '{32'h0, 32'h190, 32'h190, 32'h320, 32'h3E8, 32'h0};
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, offs[i], 32'h0);
      `CHK("reset value", exps[i], rd)
    end
    bus(1'b1, 8'h20, 32'h5A5A5A5A);  // Unmapped write ignored
    bus(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    bus(1'b1, 8'h04, 32'h5DD);  // Level above range clamps
    bus(1'b0, 8'h04, 32'h0);
    `CHK("level clamp", 32'h5DC, rd)
    bus(1'b1, 8'h04, 32'h190);
    bus(1'b1, 8'h14, 32'hAFC81);
    bus(1'b0, 8'h14, 32'h0);
    `CHK("delay clamp", 32'hAFC80, rd)
    bus(1'b1, 8'h14, 32'h0);
    $display("regs done");
  endtask

  task automatic t_alarms;
    setc(16'h01F4, 1'b0);  // Enables still off
    `CHK("gated off", 3'h0, {alarm1Out, alarm2Out, inhibitOut})
    bus(1'b1, 8'h00, 32'h7);
    bus(1'b1, 8'h08, 32'h191);  // Second level one step higher
    setc(16'h018F, 1'b0);
    `CHK("alarm1 below", 1'b0, alarm1Out)
    `CHK("cond normal", 3'h0, condition)
    setc(16'h0190, 1'b0);
    `CHK("alarm1 at", 1'b1, alarm1Out)
    `CHK("alarm2 own", 1'b0, alarm2Out)
    `CHK("cond alarm1", 3'h1, condition)
    setc(16'h0320, 1'b0);
    `CHK("alarm2 inhibit", 2'h3, {alarm2Out, inhibitOut})
    setc(16'h0064, 1'b0);
    `CHK("alarms drop", 3'h0, {alarm1Out, alarm2Out, inhibitOut})
    $display("alarms done");
  endtask

  task automatic t_trip;
    int k;
    setc(16'h03E8, 1'b0);
    `CHK("trip no delay", 2'h3, {tripOut, startOut})
    `CHK("cond trip", 3'h4, condition)
    setc(16'h03E7, 1'b0);
    `CHK("trip drop", 1'b0, tripOut)
    bus(1'b1, 8'h14, 32'h3);
    @(posedge clock);
    capReq <= 16'h03E8;
    @(posedge clock iff (cycleStart === 1'b1 && capacity === 16'h03E8));
    k = 0;
    do begin @(negedge clock); k++; end while (tripOut !== 1'b1 && k < 100);
    `CHK("trip delay", 3 * STEP + 2, k)
    setc(16'h03E7, 1'b0);
    @(posedge clock);
    capReq <= 16'h03E8;
    @(posedge clock iff (cycleStart === 1'b1 && capacity === 16'h03E8));
    capReq <= 16'h03E7;  // Dip mid-delay restarts the timer
    @(posedge clock iff cycleStart === 1'b1);
    capReq <= 16'h03E8;
    k = 0;
    do begin @(negedge clock); k++; end while (tripOut !== 1'b1 && k < 100);
    `CHK("timer restart", PER + 3 * STEP + 2, k)
    setc(16'h0064, 1'b0);
    $display("trip done");
  endtask

  task automatic t_block;
    bus(1'b1, 8'h14, 32'h4);  // Leaves room for early blocking
    setc(16'h01F4, 1'b1);
    `CHK("blocked no pickup", 1'b0, blockedOut)
    @(posedge clock);
    capReq <= 16'h03E8;
    blkReq <= 1'b0;
    @(posedge clock iff (cycleStart === 1'b1 && capacity === 16'h03E8));
    blkReq <= 1'b1;
    @(negedge clock);
    `CHK("start", 1'b1, startOut)
    settle;
    `CHK("start cleared", 3'h4, {blockedOut, startOut, tripOut})
    `CHK("cond blocked", 3'h5, condition)
    setc(16'h0064, 1'b0);
    bus(1'b1, 8'h14, 32'h0);
    $display("block done");
  endtask

  task automatic t_node;
    logic [2:0] e;
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, 8'h00, 32'h7 | (m << 4));
      setc(16'h03E8, 1'b0);
      e = (m > 4) ? 3'h4 : m[2:0];
      `CHK("node mode", e, lnBehaviour)
      bus(1'b0, 8'h18, 32'h0);
      `CHK("status mode", e, rd[14:12])
      `CHK("trip by mode", (m == 0 || m == 2), tripOut)
      `CHK("block by mode", (m == 1 || m == 3), blockedOut)
    end
    bus(1'b1, 8'h00, 32'h7);
    setc(16'h0064, 1'b0);
    $display("node done");
  endtask

  task automatic t_load;
    logic [15:0] cur [5] = '{16'h0009, 16'h000A, 16'h03E8, 16'h07D0, 16'h07D1};
    logic [1:0]  exl [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      measCurrent <= cur[i];
      settle;
      `CHK("load", exl[i], loadStatus)
    end
    $display("load done");
  endtask

  task automatic t_faults;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      bad <= 4'h1 << i;
      @(posedge clock);
      @(negedge clock);
      `CHK("fault flag", 4'h1 << i, {ambKFault, nomFault, ambFault, sfFault})
    end
    `CHK("k no substitute", 16'h0140, ambKUsed)
    @(posedge clock);
    bad <= 4'hF;
    repeat (2) @(negedge clock);
    `CHK("used values", 48'h010001000100, {sfUsed, ambKUsed, nomCurrUsed})
    bus(1'b0, 8'h18, 32'h0);
    `CHK("status faults", 4'hF, rd[23:20])
    @(posedge clock);
    bad <= 4'h0;
    repeat (2) @(negedge clock);
    `CHK("used restore", 48'h0180014000C0, {sfUsed, ambKUsed, nomCurrUsed})
    $display("faults done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {avsRead, avsWrite, blkReq} = 3'h0;
    avsAddress = 8'h00;
    avsWriteData = 32'h0;
    capReq = 16'h0000;
    measCurrent = 16'h0064;
    serviceFactor = 16'h0180;
    bad = 4'h0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_regs;
    t_alarms;
    t_trip;
    t_block;
    t_node;
    t_load;
    t_faults;
    final_report;
  end
endmodule  // tos_output_stage_tb

`default_nettype wire
